// >>> bench/clkgen_checker.sv
// port-level assertions for the clock generator
`timescale 1ns/1ps
module clkgen_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic osc_enable,
    input wire logic osc_bypass,
    input wire logic osc_high_gain,
    input wire logic osc_range_high,
    input wire logic external_reference_clock,
    input wire logic fixed_freq_enable,
    input wire logic debug_local_clock
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic pins = osc_enable || osc_bypass;

    chk_write_answer: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
        |-> ##[1:2] s_axi_bvalid) else $error("write response late");
    chk_read_answer: assert property ((s_axi_arvalid && s_axi_arready) |-> ##[1:2] s_axi_rvalid)
        else $error("read response late");
    chk_bresp_stands: assert property ((s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_rdata_stands: assert property ((s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_osc_exclusive: assert property (!(osc_enable && osc_bypass))
        else $error("amplifier and bypass both on");
    chk_pins_gated: assert property (!pins |-> !osc_high_gain && !osc_range_high && !external_reference_clock)
        else $error("oscillator used without pins");
    chk_gain_once: assert property (($past(pins) && pins) |-> $stable(osc_high_gain))
        else $error("gain changed after first write");
    chk_debug_period: assert property ($rose(debug_local_clock) |-> ##5 $rose(debug_local_clock))
        else $error("debug clock period wrong");
    chk_ffe_needs_ref: assert property (fixed_freq_enable |-> pins)
        else $error("fixed enable without external source");

    cover property (s_axi_bvalid && s_axi_bready);
    cover property (fixed_freq_enable);
    cover property (osc_bypass && osc_high_gain);
endmodule

bind clkgen_top clkgen_checker i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .osc_enable, .osc_bypass, .osc_high_gain,
    .osc_range_high, .external_reference_clock, .fixed_freq_enable, .debug_local_clock);

// >>> bench/clkgen_ext_osc.sv
// external square-wave source, stops low when not running
`timescale 1ns/1ps
module clkgen_ext_osc #(
    parameter realtime HALF_NS = 170
) (
    input wire logic run,
    output logic pin
);
    initial pin = 1'b0;
    always begin
        #(HALF_NS);
        pin = run ? ~pin : 1'b0;
    end
endmodule

// >>> bench/test_internal_clock_generator.sv
// testbench for the clock generator
`timescale 1ns/1ps
module test_internal_clock_generator;
    import clkgen_pkg::*;
    logic aclk = 0, aresetn = 0, run = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ext_clk_pin;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic osc_enable, osc_bypass, osc_high_gain, osc_range_high, fll_output_clock, irq;
    logic external_reference_clock, fixed_freq_enable, debug_local_clock, generator_output_clock;
    int mismatches = 0, checks_done = 0;
    always #12.5 aclk = ~aclk;

    clkgen_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ext_clk_pin, .osc_enable, .osc_bypass, .osc_high_gain, .osc_range_high,
        .fll_output_clock, .external_reference_clock, .fixed_freq_enable, .debug_local_clock,
        .generator_output_clock, .irq);
    clkgen_ext_osc i_osc (.run(run), .pin(ext_clk_pin));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        rdat = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 0;
    endtask

    // rising edges of a clock output over a window; 0 loop, 1 ext ref, 2 generator, 3 debug
    task automatic rises(input int sel, input int n, output int c);
        logic v, p;
        c = 0;
        p = 0;
        repeat (n) begin
            @(posedge aclk);
            v = sel == 0 ? fll_output_clock : sel == 1 ? external_reference_clock :
                sel == 2 ? generator_output_clock : debug_local_clock;
            if (v && !p) c++;
            p = v;
        end
    endtask

    task automatic t_reset_values();
        logic [7:0] ofs [6] = '{OFS_CTRL1, OFS_CTRL2, OFS_STAT, OFS_MASK, OFS_TRIM, OFS_FILT};
        logic [31:0] exp [6] = '{0, 32'(MULT_RST) << C2_MULT_LSB, 0, 0, 32'(TRIM_RST), 32'(FILT_RST)};
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i]);
            check("reset value", rdat, exp[i]);
        end
        rd(8'h18);
        check("unmapped read", rdat, 32'h0);
        check("unmapped rresp", rsp, RESP_SLVERR);
        wr(8'h18, 32'hFFFFFFFF);
        check("unmapped write", rsp, RESP_SLVERR);
        wr(OFS_TRIM, 32'h55);
        rd(OFS_TRIM);
        check("trim", rdat, 32'h55);
    endtask

    task automatic t_divider();
        int c, c0;
        for (int n = 0; n < 8; n++) begin
            wr(OFS_CTRL2, (32'(MULT_RST) << C2_MULT_LSB) | n);
            rises(0, 4096, c);
            if (n == 0) c0 = c;
            check("divided rate", (c - (c0 >> n)) inside {[-1:1]}, 1);
        end
        check("free running", c0 > 8, 1);
        rises(3, 500, c);
        check("debug rate", (c - 500 / DBG_CYC) inside {[-1:1]}, 1);
    endtask

    task automatic t_first_write();
        wr(OFS_CTRL1, 32'hD8);
        repeat (2) @(posedge aclk);
        check("pins first", {osc_enable, osc_bypass, osc_high_gain, osc_range_high}, 4'hB);
        rd(OFS_STAT);
        check("pins status", rdat[ST_PINS_EN], 1);
        wr(OFS_CTRL1, 32'h30);
        repeat (2) @(posedge aclk);
        check("pins second", {osc_enable, osc_bypass, osc_high_gain, osc_range_high}, 4'h6);
    endtask

    task automatic t_ext_ref();
        int c;
        run <= 1;
        repeat (200) @(posedge aclk);
        rises(1, 1360, c);
        check("ext ref rate", (c - 100) inside {[-2:2]}, 1);
        rises(2, 1360, c);
        check("selected rate", (c - 100) inside {[-2:2]}, 1);
        rd(OFS_STAT);
        check("ref valid", rdat[ST_REF_VALID], 1);
        check("fixed enable on", fixed_freq_enable, 1);
        run <= 0;
        repeat (REF_LOSS_CYC + 100) @(posedge aclk);
        rd(OFS_STAT);
        check("ref lost", rdat & 32'h14, 32'h4);
        check("fixed enable off", fixed_freq_enable, 0);
        check("irq masked", irq, 0);
        wr(OFS_MASK, 32'h4);
        repeat (3) @(posedge aclk);
        check("irq raised", irq, 1);
        wr(OFS_STAT, 32'h4);
        repeat (3) @(posedge aclk);
        check("irq cleared", irq, 0);
        rd(OFS_STAT);
        check("sticky cleared", rdat[ST_REF_LOST], 0);
    endtask

    task automatic t_lock();
        wr(OFS_TRIM, 32'(TRIM_RST));
        wr(OFS_CTRL2, 32'h0);
        wr(OFS_FILT, 32'hC7CE);
        wr(OFS_CTRL1, 32'h8);
        repeat (8 * IREF_CYC) @(posedge aclk);
        rd(OFS_STAT);
        check("lock acquired", rdat & 32'hB, 32'h9);
        wr(OFS_FILT, 32'h1000);
        repeat (2 * IREF_CYC) @(posedge aclk);
        rd(OFS_STAT);
        check("lock lost", rdat & 32'hB, 32'h3);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #(25 * 60000);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset_values();
        t_divider();
        t_first_write();
        t_ext_ref();
        t_lock();
        tally_and_finish();
    end
endmodule

// >>> design/clkgen_pkg.sv
// constants, register map and types for the clock generator
package clkgen_pkg;

    localparam int AXI_AW = 8;
    localparam int CLK_MHZ = 40;

    localparam logic [7:0] OFS_CTRL1 = 8'h00;
    localparam logic [7:0] OFS_CTRL2 = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;
    localparam logic [7:0] OFS_TRIM = 8'h10;
    localparam logic [7:0] OFS_FILT = 8'h14;

    // control one fields
    localparam int C1_GAIN_BIT = 7;
    localparam int C1_RANGE_BIT = 6;
    localparam int C1_SQW_BIT = 5;
    localparam int C1_MODE_LSB = 3;
    // control two fields
    localparam int C2_DIV_LSB = 0;
    localparam int C2_MULT_LSB = 4;
    // status: sticky bits 2:0, levels above
    localparam int ST_LOCK_ACQ = 0;
    localparam int ST_LOCK_LOST = 1;
    localparam int ST_REF_LOST = 2;
    localparam int ST_LOCKED = 3;
    localparam int ST_REF_VALID = 4;
    localparam int ST_PINS_EN = 5;

    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic [2:0] MULT_RST = 3'h3;
    localparam logic [7:0] TRIM_RST = 8'h80;
    localparam logic [15:0] FILT_RST = 16'h1000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // timing
    localparam int IREF_KHZ = 243;
    localparam int IREF_CYC = (CLK_MHZ * 1000) / IREF_KHZ;
    localparam int DBG_MHZ = 8;
    localparam int DBG_CYC = CLK_MHZ / DBG_MHZ;
    localparam int REF_LOSS_NS = 50000;
    localparam int REF_LOSS_CYC = (REF_LOSS_NS * CLK_MHZ) / 1000;
    localparam int LOCK_TOL = 2;
    localparam int LOCK_WINDOWS = 4;

    typedef enum logic [1:0] {
        MODE_SCM,
        MODE_FEI,
        MODE_FBE,
        MODE_FEE
    } clkgen_mode_e;

    typedef enum logic [1:0] {
        SW_RUN,
        SW_WAIT
    } clkgen_sw_e;

endpackage

// >>> design/clkgen_tick.sv
// programmable period divider giving a clock level and a tick pulse
`timescale 1ns/1ps
module clkgen_tick #(
    parameter int W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] period,
    output logic clk_out,
    output logic tick
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] half;

    if (W < 3) begin : g_chk
        $error("clkgen_tick: W too small");
    end

    assign half = period >> 1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= '0;
            tick <= 1'b0;
            clk_out <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (cnt_reg + W'(1) >= period) begin
                cnt_reg <= '0;
                tick <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + W'(1);
            end
            clk_out <= (cnt_reg < half);
        end
    end
endmodule

// >>> design/clkgen_top.sv
// clock generator core: oscillator control, references, loop, clock select, axi4-lite registers
// Functional notes
// RQ1 - two software selected oscillator frequency ranges
// RQ2 - oscillator can pass an external square wave through
// RQ3 - high gain select picks low power or high amplitude mode
// RQ4 - about 8 MHz internal source usable as debug controller clock
// RQ5 - 243 kHz internal source has a software writable trim
// RQ6 - loop uses internal or external reference and multiplies it
// RQ7 - status bits report lock acquired and lock lost
// RQ8 - external reference monitored, valid status reported
// RQ9 - multiplied loop output offered as its own clock
// RQ10 - unmultiplied external source offered as reference clock output
// RQ11 - fixed frequency enable output governs fixed frequency clock
// RQ12 - dedicated local clock output for the debug controller
// RQ13 - programmer keeps memory location 0xFFBE for a trim copy
// RQ14 - after reset: self clocked, loop open, oscillator at filter value
// RQ15 - post loop divider picks one of eight divisors, /1 to /128
// RQ16 - high gain select takes only its first write after reset
// RQ17 - oscillator pins used only if first control write picks external mode
// RQ18 - output source switching never makes runt pulses
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module clkgen_top #(
    parameter int FILT_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [clkgen_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [clkgen_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_clk_pin,
    output logic osc_enable,
    output logic osc_bypass,
    output logic osc_high_gain,
    output logic osc_range_high,
    output logic fll_output_clock,
    output logic external_reference_clock,
    output logic fixed_freq_enable,
    output logic debug_local_clock,
    output logic generator_output_clock,
    output logic irq
);
    import clkgen_pkg::*;

    if (FILT_W != 16) begin : g_chk
        $error("clkgen_top: FILT_W must be 16");
    end

    function automatic logic mapped(input logic [AXI_AW-1:0] a);
        mapped = (a == OFS_CTRL1) || (a == OFS_CTRL2) || (a == OFS_STAT) ||
                 (a == OFS_MASK) || (a == OFS_TRIM) || (a == OFS_FILT);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        merge = r;
    endfunction

    function automatic logic ext_mode(input clkgen_mode_e m);
        ext_mode = (m == MODE_FBE) || (m == MODE_FEE);
    endfunction

    // bus slave state
    logic aw_got_reg;
    logic w_got_reg;
    logic [AXI_AW-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_do;
    logic [31:0] wr_word;
    logic [31:0] rd_word;
    logic [31:0] old_word;

    // control state
    logic gain_reg;
    logic range_reg;
    logic sqw_reg;
    logic c1_written_reg;
    logic pins_en_reg;
    clkgen_mode_e mode_reg;
    logic [2:0] div_reg;
    logic [2:0] mult_reg;
    logic [7:0] trim_reg;
    logic [FILT_W-1:0] filt_reg;
    logic [2:0] sticky_reg;
    logic [2:0] mask_reg;
    logic [2:0] sticky_set;

    // reference and loop state
    logic ext_s1_reg;
    logic ext_s2_reg;
    logic ext_s3_reg;
    logic ext_lvl;
    logic ext_rise;
    logic [11:0] loss_cnt_reg;
    logic ref_valid_reg;
    logic iref_tick;
    logic dbg_clk;
    logic [FILT_W-1:0] acc_reg;
    logic [FILT_W:0] acc_sum;
    logic [7:0] pd_cnt_reg;
    logic dco_tick_reg;
    logic [9:0] edge_cnt_reg;
    logic [9:0] target;
    logic engaged;
    logic ref_edge;
    logic [2:0] win_cnt_reg;
    logic locked_reg;
    logic too_slow;
    logic too_fast;
    logic fll_clk;
    clkgen_sw_e sw_reg;
    logic cur_ext_reg;
    logic want_ext;
    logic src_cur;
    logic src_new;

    assign wr_do = aw_got_reg && w_got_reg && !s_axi_bvalid;
    assign wr_word = merge(old_word & 32'h0000FFFF, wdata_reg, wstrb_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // register contents at an address, for reads and write merges
    function automatic logic [31:0] reg_word(input logic [AXI_AW-1:0] a);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            OFS_CTRL1: begin
                v[C1_GAIN_BIT] = gain_reg;
                v[C1_RANGE_BIT] = range_reg;
                v[C1_SQW_BIT] = sqw_reg;
                v[C1_MODE_LSB +: 2] = mode_reg;
            end
            OFS_CTRL2: begin
                v[C2_DIV_LSB +: 3] = div_reg;
                v[C2_MULT_LSB +: 3] = mult_reg;
            end
            OFS_STAT: begin
                v[2:0] = sticky_reg;
                v[ST_LOCKED] = locked_reg;
                v[ST_REF_VALID] = ref_valid_reg;
                v[ST_PINS_EN] = pins_en_reg;
            end
            OFS_MASK: v[2:0] = mask_reg;
            OFS_TRIM: v[7:0] = trim_reg;
            OFS_FILT: v[FILT_W-1:0] = filt_reg;
            default: v = 32'h0;
        endcase
        reg_word = v;
    endfunction

    always_comb begin
        rd_word = reg_word(s_axi_araddr);
        old_word = reg_word(awaddr_reg);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // first control write fixes gain and pin use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gain_reg <= 1'b0;
            range_reg <= 1'b0;
            sqw_reg <= 1'b0;
            mode_reg <= MODE_SCM; // see RQ14
            c1_written_reg <= 1'b0;
            pins_en_reg <= 1'b0;
        end else if (wr_do && awaddr_reg == OFS_CTRL1 && wstrb_reg[0]) begin
            c1_written_reg <= 1'b1;
            range_reg <= wdata_reg[C1_RANGE_BIT]; // see RQ1
            sqw_reg <= wdata_reg[C1_SQW_BIT]; // see RQ2
            mode_reg <= clkgen_mode_e'(wdata_reg[C1_MODE_LSB +: 2]);
            if (!c1_written_reg) begin
                gain_reg <= wdata_reg[C1_GAIN_BIT]; // see RQ16
                pins_en_reg <= ext_mode(clkgen_mode_e'(wdata_reg[C1_MODE_LSB +: 2])); // see RQ17
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_reg <= DIV_RST;
            mult_reg <= MULT_RST;
            trim_reg <= TRIM_RST;
            mask_reg <= 3'h0;
        end else if (wr_do) begin
            if (awaddr_reg == OFS_CTRL2) begin
                div_reg <= wr_word[C2_DIV_LSB +: 3]; // see RQ15
                mult_reg <= wr_word[C2_MULT_LSB +: 3];
            end
            if (awaddr_reg == OFS_TRIM) begin
                trim_reg <= wr_word[7:0]; // see RQ5
            end
            if (awaddr_reg == OFS_MASK) begin
                mask_reg <= wr_word[2:0];
            end
        end
    end

    // sticky status, write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sticky_reg <= 3'h0;
            irq <= 1'b0;
        end else begin
            if (wr_do && awaddr_reg == OFS_STAT && wstrb_reg[0]) begin
                sticky_reg <= (sticky_reg & ~wr_word[2:0]) | sticky_set;
            end else begin
                sticky_reg <= sticky_reg | sticky_set;
            end
            irq <= |(sticky_reg & mask_reg);
        end
    end

    // oscillator pin controls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_enable <= 1'b0;
            osc_bypass <= 1'b0;
            osc_high_gain <= 1'b0;
            osc_range_high <= 1'b0;
        end else begin
            osc_enable <= pins_en_reg && !sqw_reg; // see RQ17
            osc_bypass <= pins_en_reg && sqw_reg; // see RQ2
            osc_high_gain <= pins_en_reg && gain_reg; // see RQ3
            osc_range_high <= pins_en_reg && range_reg; // see RQ1
        end
    end

    // external reference synchroniser and monitor
    assign ext_lvl = ext_s2_reg && pins_en_reg;
    assign ext_rise = ext_lvl && !ext_s3_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
            loss_cnt_reg <= '0;
            ref_valid_reg <= 1'b0;
        end else begin
            ext_s1_reg <= ext_clk_pin;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_lvl;
            if (ext_rise) begin
                loss_cnt_reg <= '0;
                ref_valid_reg <= 1'b1; // see RQ8
            end else if (loss_cnt_reg >= 12'(REF_LOSS_CYC - 1)) begin
                ref_valid_reg <= 1'b0; // see RQ8
            end else begin
                loss_cnt_reg <= loss_cnt_reg + 12'h1;
            end
        end
    end

    clkgen_tick #(.W(16)) u_iref (
        .aclk(aclk),
        .aresetn(aresetn),
        .period(16'(IREF_CYC) + {8'h00, trim_reg} - 16'h0080), // see RQ5
        .clk_out(),
        .tick(iref_tick)
    );

    clkgen_tick #(.W(16)) u_dbg (
        .aclk(aclk),
        .aresetn(aresetn),
        .period(16'(DBG_CYC)), // see RQ4
        .clk_out(dbg_clk),
        .tick()
    );

    // digitally controlled oscillator and post divider
    assign acc_sum = {1'b0, acc_reg} + {1'b0, filt_reg};
    assign fll_clk = pd_cnt_reg[div_reg];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_reg <= '0;
            dco_tick_reg <= 1'b0;
            pd_cnt_reg <= 8'h00;
        end else begin
            acc_reg <= acc_sum[FILT_W-1:0]; // see RQ14
            dco_tick_reg <= acc_sum[FILT_W];
            if (dco_tick_reg) begin
                pd_cnt_reg <= pd_cnt_reg + 8'h01; // see RQ15
            end
        end
    end

    // frequency-locked loop
    assign engaged = (mode_reg == MODE_FEI) || (mode_reg == MODE_FEE);
    assign ref_edge = (mode_reg == MODE_FEE) ? (ext_rise && ref_valid_reg) : iref_tick; // see RQ6
    assign target = {1'b0, mult_reg, 6'h00} + 10'h040;
    assign too_slow = edge_cnt_reg + 10'(LOCK_TOL) < target;
    assign too_fast = edge_cnt_reg > target + 10'(LOCK_TOL);

    always_comb begin
        sticky_set = 3'h0;
        if (engaged && ref_edge) begin
            if (!too_slow && !too_fast && !locked_reg && win_cnt_reg == 3'(LOCK_WINDOWS - 1)) begin
                sticky_set[ST_LOCK_ACQ] = 1'b1; // see RQ7
            end
            if ((too_slow || too_fast) && locked_reg) begin
                sticky_set[ST_LOCK_LOST] = 1'b1; // see RQ7
            end
        end
        if (pins_en_reg && ref_valid_reg && loss_cnt_reg >= 12'(REF_LOSS_CYC - 1) && !ext_rise) begin
            sticky_set[ST_REF_LOST] = 1'b1; // see RQ8
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt_reg <= FILT_RST;
            edge_cnt_reg <= '0;
            win_cnt_reg <= '0;
            locked_reg <= 1'b0;
        end else if (wr_do && awaddr_reg == OFS_FILT) begin
            filt_reg <= wr_word[FILT_W-1:0];
        end else if (!engaged) begin
            edge_cnt_reg <= '0;
            win_cnt_reg <= '0;
            locked_reg <= 1'b0;
        end else if (ref_edge) begin
            edge_cnt_reg <= '0;
            if (too_slow) begin
                filt_reg <= filt_reg + FILT_W'(1); // see RQ6
            end else if (too_fast) begin
                filt_reg <= filt_reg - FILT_W'(1);
            end
            if (too_slow || too_fast) begin
                win_cnt_reg <= '0;
                locked_reg <= 1'b0; // see RQ7
            end else if (win_cnt_reg == 3'(LOCK_WINDOWS - 1)) begin
                locked_reg <= 1'b1; // see RQ7
            end else begin
                win_cnt_reg <= win_cnt_reg + 3'h1;
            end
        end else if (dco_tick_reg && !pd_cnt_reg[0]) begin
            edge_cnt_reg <= edge_cnt_reg + 10'h001;
        end
    end

    // clock outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fll_output_clock <= 1'b0;
            external_reference_clock <= 1'b0;
            fixed_freq_enable <= 1'b0;
            debug_local_clock <= 1'b0;
        end else begin
            fll_output_clock <= fll_clk; // see RQ9
            external_reference_clock <= ext_lvl; // see RQ10
            fixed_freq_enable <= ext_mode(mode_reg) && ref_valid_reg; // see RQ11
            debug_local_clock <= dbg_clk; // see RQ12
        end
    end

    // glitch-free source select for the generator output
    assign want_ext = (mode_reg == MODE_FBE);
    assign src_cur = cur_ext_reg ? ext_lvl : fll_clk;
    assign src_new = want_ext ? ext_lvl : fll_clk;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_reg <= SW_RUN;
            cur_ext_reg <= 1'b0;
            generator_output_clock <= 1'b0;
        end else begin
            case (sw_reg)
                SW_RUN: begin
                    generator_output_clock <= src_cur;
                    if (want_ext != cur_ext_reg && !src_cur) begin
                        generator_output_clock <= 1'b0; // see RQ18
                        sw_reg <= SW_WAIT;
                    end
                end
                SW_WAIT: begin
                    generator_output_clock <= 1'b0;
                    if (!src_new) begin
                        cur_ext_reg <= want_ext; // see RQ18
                        sw_reg <= SW_RUN;
                    end
                end
                default: sw_reg <= SW_RUN;
            endcase
        end
    end
endmodule
